// File: tb/sflt_core_sva.sv
// Port checker of the starter fault log and test block
`timescale 1ns/100ps
module sflt_core_sva (
	input wire logic mclk,
	input wire logic rst,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_rdata,
	input wire logic do_cw,
	input wire logic do_ccw,
	input wire logic off_cmd,
	input wire logic brake_cmd,
	input wire logic monitor_fail,
	input wire logic motor_cw,
	input wire logic motor_ccw,
	input wire logic brake_on,
	input wire logic motor_model_clear,
	input wire logic device_led_red
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	sequence s_both_rise;
		!do_cw && !do_ccw ##1 do_cw && do_ccw;
	endsequence
	// The rise cycle itself is a reset request, so only a held pattern is an error
	sequence s_both_held;
		s_both_rise ##1 (do_cw && do_ccw)[*2];
	endsequence
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
		else $error("read data outside its answer cycle");
	a_unmapped_zero: assert property (reg_rd && reg_addr > 8'h18 |=> reg_rdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_pi_blocks: assert property (s_both_held |=> !motor_cw && !motor_ccw)
		else $error("motor on with illegal output pattern");
	a_off_stops: assert property (off_cmd |=> !motor_cw && !motor_ccw)
		else $error("motor on during off command");
	a_cmd_needed: assert property (motor_cw || motor_ccw |-> $past(do_cw || do_ccw))
		else $error("motor on without run command");
	a_brake_cmd: assert property (!brake_cmd |=> !brake_on)
		else $error("brake on without brake command");
	a_clear_once: assert property (motor_model_clear |=> !motor_model_clear)
		else $error("model clear pulse too long");
	a_sterr_led: assert property ($rose(monitor_fail) |-> ##[1:4] device_led_red)
		else $error("device led not red after monitor failure");
	c_reset_pattern: cover property (s_both_rise);
endmodule : sflt_core_sva

bind sflt_core sflt_core_sva u_sva (
	.mclk(mclk),
	.rst(rst),
	.reg_rd(reg_rd),
	.reg_addr(reg_addr),
	.reg_rdata(reg_rdata),
	.do_cw(do_cw),
	.do_ccw(do_ccw),
	.off_cmd(off_cmd),
	.brake_cmd(brake_cmd),
	.monitor_fail(monitor_fail),
	.motor_cw(motor_cw),
	.motor_ccw(motor_ccw),
	.brake_on(brake_on),
	.motor_model_clear(motor_model_clear),
	.device_led_red(device_led_red)
);

// File: tb/sflt_core_tb_top.sv
// Self-checking testbench of the starter fault log and test block
`timescale 1ns/100ps
`include "sflt_defs.svh"
module sflt_core_tb_top;
	logic mclk, rst, reg_wr, reg_rd, in_emst, in_reset, limit_trip, elem_defective;
	logic elem_overload, monitor_fail, test_cmd, switched_supply, electronics_supply;
	logic key_zero, disconnect_on, do_cw, do_ccw, off_cmd, brake_cmd, blocking_trip, current_flow;
	logic motor_cw, motor_ccw, brake_on, motor_model_clear;
	logic device_led_red, group_fault_led, status_led;
	logic [7:0] reg_addr, fault_cause, mlatch;
	logic [31:0] reg_wdata, reg_rdata, d;
	logic [6:0] warn;
	logic [3:0] want;
	int err_total, n_checks, n_clr, k;
	int seed = 80755;
	int q[3][$];
	sflt_plc u_plc (.mclk(mclk), .want(want), .do_cw(do_cw), .do_ccw(do_ccw),
		.off_cmd(off_cmd), .brake_cmd(brake_cmd));
	sflt_core #(.TENTH_CYC(10)) DUT (.mclk(mclk), .rst(rst), .ce(1'b1),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .do_cw(do_cw), .do_ccw(do_ccw), .off_cmd(off_cmd),
		.brake_cmd(brake_cmd), .in_emst(in_emst), .in_reset(in_reset),
		.fault_cause(fault_cause), .warn(warn), .limit_trip(limit_trip),
		.elem_defective(elem_defective), .elem_overload(elem_overload),
		.blocking_trip(blocking_trip), .monitor_fail(monitor_fail),
		.current_flow(current_flow),
		.test_cmd(test_cmd), .switched_supply(switched_supply),
		.electronics_supply(electronics_supply), .key_zero(key_zero),
		.disconnect_on(disconnect_on), .motor_cw(motor_cw), .motor_ccw(motor_ccw),
		.brake_on(brake_on), .motor_model_clear(motor_model_clear),
		.device_led_red(device_led_red), .group_fault_led(group_fault_led),
		.status_led(status_led));
	initial begin
		mclk = 0;
		forever #4 mclk = ~mclk;
	end
	always @(posedge mclk) if (motor_model_clear === 1'b1) n_clr++;
	task conclude;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : conclude
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task tick(input int n);
		repeat (n) @(posedge mclk);
	endtask : tick
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge mclk);
		reg_wr <= 1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge mclk);
		reg_wr <= 0;
	endtask : wr
	task rchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
		@(posedge mclk);
		reg_rd <= 1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 0;
		#1 d = reg_rdata;
		chk(d & m, exp);
	endtask : rchk
	task lchk(input int b, input int idx);
		int n;
		int c;
		logic [31:0] e;
		n = q[b].size();
		c = (n > 21) ? 21 : n;
		e = c << 8;
		if (idx < c) e = e | q[b][n - 1 - idx];
		wr(`SFLT_REG_LOGSEL, (idx << 8) | b);
		rchk(`SFLT_REG_LOGCODE, e, 32'hffff_ffff);
	endtask : lchk
	// Model latch: a cause is logged only when it rises against the latch
	task cause(input logic [7:0] v);
		@(posedge mclk);
		fault_cause <= v;
		for (int b = 0; b < 8; b++) if (v[b] && !mlatch[b]) q[0].push_back(b);
		mlatch = mlatch | v;
		tick(3);
	endtask : cause
	task pulse_reset;
		@(posedge mclk);
		in_reset <= 1;
		@(posedge mclk);
		in_reset <= 0;
		mlatch = fault_cause;
		tick(3);
	endtask : pulse_reset
	// Hardware test: flash toggles twice and flicker ten times in 100 cycles
	task hw_test(input logic flow, input int exp);
		int n;
		logic lv;
		current_flow <= flow;
		test_cmd <= 1;
		tick(300);
		test_cmd <= 0;
		tick(5);
		n = 0;
		repeat (100) begin
			lv = device_led_red;
			tick(1);
			if (device_led_red !== lv) n++;
		end
		chk(n, exp);
		tick(120);
	endtask : hw_test
	task trigger(input int s);
		case (s)
			0: pulse_reset();
			1: wr(`SFLT_REG_CMD, 32'h0000_0020);
			2: begin key_zero <= 1; tick(4); key_zero <= 0; end
			3: begin disconnect_on <= 1; tick(4); disconnect_on <= 0; end
			4: begin switched_supply <= 0; tick(4); switched_supply <= 1; end
			default: begin want <= 4'h3; tick(5); want <= 4'h0; end
		endcase
		tick(6);
	endtask : trigger
	initial begin
		repeat (100000) @(posedge mclk);
		err_total++;
		conclude();
	end
	initial begin
		{rst, reg_wr, reg_rd, in_emst, in_reset, limit_trip, elem_defective} = 7'h7f & 7'h40;
		{elem_overload, monitor_fail, test_cmd, key_zero, disconnect_on} = 5'h00;
		{blocking_trip, current_flow} = 2'b00;
		{switched_supply, electronics_supply} = 2'b11;
		{reg_addr, fault_cause, mlatch, reg_wdata, warn, want} = 0;
		tick(12);
		rst <= 0;
		rchk(`SFLT_REG_STATUS, 32'h0000_0000, 32'hffff_ffff);
		rchk(`SFLT_REG_CFG, `SFLT_CFG_RST, 32'hffff_ffff);
		rchk(8'h1c, 32'h0000_0000, 32'hffff_ffff);
		d = $random(seed);
		wr(`SFLT_REG_CFG, d);
		rchk(`SFLT_REG_CFG, d & 32'h0000_ffff, 32'hffff_ffff);
		wr(`SFLT_REG_CFG, 32'h0000_0000);
		for (k = 0; k < 23; k++) begin
			cause(8'h01 << ($unsigned($random(seed)) % 8));
			cause(8'h00);
			trigger(0);
		end
		lchk(0, 0);
		lchk(0, 20);
		lchk(0, 21);
		for (k = 0; k < 6; k++) begin
			cause(8'h28);
			cause(8'h20);
			trigger(k);
			mlatch = 8'h20;
			rchk(`SFLT_REG_STATUS, 32'h0020_0000, 32'h00ff_0000);
		end
		wr(`SFLT_REG_CFG, 32'h0000_0001);
		cause(8'h28);
		cause(8'h20);
		trigger(4);
		rchk(`SFLT_REG_STATUS, 32'h0028_0000, 32'h00ff_0000);
		wr(`SFLT_REG_CFG, 32'h0000_0000);
		warn <= 7'h04;
		tick(3);
		warn <= 7'h00;
		tick(3);
		q[1].push_back(2);
		q[1].push_back(8'h82);
		lchk(1, 1);
		cause(8'h01);
		want <= 4'h1;
		tick(4);
		chk(motor_cw, 1'b0);
		wr(`SFLT_REG_CMD, 32'h0000_0004);
		q[1].push_back(7);
		tick(3);
		chk(motor_cw, 1'b1);
		want <= 4'h5;
		tick(3);
		chk({motor_cw, motor_ccw}, 2'b00);
		blocking_trip <= 1;
		want <= 4'h1;
		tick(3);
		chk(motor_cw, 1'b0);
		blocking_trip <= 0;
		tick(3);
		chk(motor_cw, 1'b1);
		limit_trip <= 1;
		tick(3);
		chk({motor_cw, motor_ccw}, 2'b01);
		limit_trip <= 0;
		elem_overload <= 1;
		tick(3);
		chk(motor_cw, 1'b0);
		elem_overload <= 0;
		electronics_supply <= 0;
		tick(6);
		chk(motor_cw, 1'b0);
		wr(`SFLT_REG_CFG, 32'h0000_0300);
		electronics_supply <= 1;
		want <= 4'h8;
		tick(6);
		chk(brake_on, 1'b0);
		tick(40);
		chk(brake_on, 1'b1);
		rchk(`SFLT_REG_STATUS, 32'h0000_0002, 32'h0000_0002);
		wr(`SFLT_REG_CMD, 32'h0000_0008);
		q[1].push_back(8'h87);
		want <= 4'h0;
		rchk(`SFLT_REG_STATUS, 32'h0000_0000, 32'h0000_0002);
		in_emst <= 1;
		q[1].push_back(7);
		tick(3);
		rchk(`SFLT_REG_STATUS, 32'h0000_0002, 32'h0000_0002);
		in_emst <= 0;
		q[1].push_back(8'h87);
		tick(3);
		lchk(1, 0);
		cause(8'h00);
		pulse_reset();
		test_cmd <= 1;
		tick(50);
		test_cmd <= 0;
		tick(10);
		chk({device_led_red, group_fault_led, status_led}, 3'b111);
		tick(250);
		chk(group_fault_led, 1'b0);
		hw_test(1'b1, 2);
		hw_test(1'b0, 10);
		monitor_fail <= 1;
		q[2].push_back(0);
		@(posedge mclk) monitor_fail <= 0;
		tick(5);
		pulse_reset();
		rchk(`SFLT_REG_STATUS, 32'h0000_000c, 32'h0000_000c);
		elem_defective <= 1;
		q[2].push_back(1);
		tick(3);
		elem_defective <= 0;
		wr(`SFLT_REG_CMD, 32'h0000_0003);
		q[0].delete();
		q[1].delete();
		lchk(0, 0);
		lchk(1, 0);
		lchk(2, 0);
		wr(`SFLT_REG_CMD, 32'h0000_0010);
		tick(5);
		chk(n_clr, 0);
		wr(`SFLT_REG_CFG, 32'h0000_0002);
		wr(`SFLT_REG_CMD, 32'h0000_0010);
		tick(5);
		chk(n_clr, 1);
		rchk(`SFLT_REG_HOURS, 32'h0000_0000, 32'hffff_fffe);
		rchk(`SFLT_REG_STATUS, 32'h0000_0080, 32'h0000_0080);
		chk({group_fault_led, status_led}, 2'b00);
		test_cmd <= 1;
		tick(550);
		test_cmd <= 0;
		tick(5);
		rchk(`SFLT_REG_STATUS, 32'h0000_0180, 32'h0000_0180);
		pulse_reset();
		rchk(`SFLT_REG_STATUS, 32'h0000_0000, 32'h0000_0180);
		tick(500);
		disconnect_on <= 1;
		tick(300);
		chk({group_fault_led, status_led}, 2'b00);
		disconnect_on <= 0;
		tick(10);
		chk(n_clr, 2);
		conclude();
	end
endmodule : sflt_core_tb_top

// File: tb/sflt_plc.sv
// Bus master model driving the starter output bits and commands
`timescale 1ns/100ps
module sflt_plc (
	input wire logic mclk,
	input wire logic [3:0] want,
	output logic do_cw,
	output logic do_ccw,
	output logic off_cmd,
	output logic brake_cmd
);
	initial begin
		do_cw = 0;
		do_ccw = 0;
		off_cmd = 0;
		brake_cmd = 0;
	end
	// Both direction bits move on one edge, so a reset pattern has both edges in one cycle
	always @(posedge mclk) begin
		do_cw <= want[0];
		do_ccw <= want[1];
		off_cmd <= want[2];
		brake_cmd <= want[3];
	end
endmodule : sflt_plc

// File: verilog/sflt_core.sv
// Starter fault logbooks, emergency start, trip reset, self-test and factory reset
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/100ps
`include "sflt_defs.svh"
//
// Contract
// - Each logbook keeps newest 21 entries, oldest overwritten.
// - Three logbooks: trips, events, device errors; stamped with operating time.
// - Trip log records each fault cause; only its delete command clears it.
// - Event log records arrivals (+) and departures (-); own delete command.
// - Device-error log records every device error; never cleared.
// - Emergency start with ON command overrides trip; limit trip reverses direction.
// - Emergency start with brake command switches brake after release delay.
// - Emergency start blocked by OFF, device errors, overload, supplies, blocking, image error.
// - Emergency start set by input action or commands; status shown while active.
// - Trip reset clears faults whose cause is gone; persisting ones stay.
// - Clockwise and counter-clockwise rising together is a remote trip reset.
// - Switched supply return resets trips only with voltage-failure protection off.
// - Input action, local interface, key zero, disconnect 0 to 1 reset trips.
// - Power-on self-test plus continuous monitoring; failure raises self-test error.
// - Test command under 2 s: all LEDs lit 2 s, no message.
// - Test 2 to 5 s: hardware test, LED flashes or flickers by current.
// - Test over 5 s: switching elements off, only in manual mode.
// - Self-test error lights device LED red, trips, clears only at power cycle.
// - Element defect trips; self-test error and defect merge into device error.
// - Factory restore clears motor model, hours, resettable faults; keeps statistics.
// - Factory command accepted only in manual mode with elements off.
// - Knob sequence within 2 to 4 s restores; device LED flashes meanwhile.
// - After restore device LED flickers 5 s; restored message cleared by reset.
// - Clockwise and counter-clockwise both requested sets process image error.
module sflt_core import sflt_pkg::*; #(
	parameter int TENTH_CYC = `SFLT_TENTH_CYC
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic do_cw,
	input wire logic do_ccw,
	input wire logic off_cmd,
	input wire logic brake_cmd,
	input wire logic in_emst,
	input wire logic in_reset,
	input wire logic [7:0] fault_cause,
	input wire logic [6:0] warn,
	input wire logic limit_trip,
	input wire logic elem_defective,
	input wire logic elem_overload,
	input wire logic blocking_trip,
	input wire logic monitor_fail,
	input wire logic current_flow,
	input wire logic test_cmd,
	input wire logic switched_supply,
	input wire logic electronics_supply,
	input wire logic key_zero,
	input wire logic disconnect_on,
	output logic motor_cw,
	output logic motor_ccw,
	output logic brake_on,
	output logic motor_model_clear,
	output logic device_led_red,
	output logic group_fault_led,
	output logic status_led
);
	logic [3:0] pin_s1, pin_s2, pin_q;
	logic [23:0] tcnt;
	logic tick;
	logic [3:0] sub_s;
	logic [31:0] op_sec;
	logic cw_q, ccw_q, emi_q, test_q;
	logic [15:0] cfg;
	logic [1:0] lsel;
	logic [4:0] lidx;
	logic emst, st_err, pi_err, ttrip, tr_done, tr_fail, fs_msg;
	logic [7:0] flt, ev_q;
	logic [1:0] dv_q;
	sflt_tst_t tst, next_tst;
	logic [7:0] tdur, ttmr, next_ttmr;
	sflt_fs_t fs, next_fs;
	logic [7:0] ftmr, next_ftmr;
	logic fs_knob;
	logic [7:0] bcnt;
	logic [2:0] blc;
	logic flash, flick;
	sflt_entry_t log_mem [0:`SFLT_LOG_COUNT-1][0:`SFLT_LOG_DEPTH-1];
	logic [4:0] wp [0:`SFLT_LOG_COUNT-1];
	logic [4:0] lcnt [0:`SFLT_LOG_COUNT-1];
	logic [15:0] pend [0:`SFLT_LOG_COUNT-1];
	logic [15:0] newv [0:`SFLT_LOG_COUNT-1];
	logic [2:0] lclr;
	logic [31:0] next_rdata;

	// Lowest pending request wins; returns found flag and index
	function automatic logic [4:0] sflt_low(input logic [15:0] v);
		logic [4:0] r;
		r = 5'h00;
		for (int i = 15; i >= 0; i--) begin
			if (v[i]) begin
				r = {1'b1, 4'(i)};
			end
		end
		return r;
	endfunction : sflt_low

	// Pins from outside the clock domain
	wire sup_sw = pin_s2[0];
	wire sup_el = pin_s2[1];
	wire sup_rise = pin_s2[0] & ~pin_q[0];
	wire key_rise = pin_s2[2] & ~pin_q[2];
	wire disc_rise = pin_s2[3] & ~pin_q[3];
	wire disc_fall = ~pin_s2[3] & pin_q[3];

	// Register decode
	wire wr_cmd = reg_wr & (reg_addr == `SFLT_REG_CMD);
	wire wr_cfg = reg_wr & (reg_addr == `SFLT_REG_CFG);
	wire wr_lsel = reg_wr & (reg_addr == `SFLT_REG_LOGSEL);
	wire c_del_trip = wr_cmd & reg_wdata[`SFLT_CMD_DEL_TRIP];
	wire c_del_ev = wr_cmd & reg_wdata[`SFLT_CMD_DEL_EV];
	wire c_emst_on = wr_cmd & reg_wdata[`SFLT_CMD_EMST_ON];
	wire c_emst_off = wr_cmd & reg_wdata[`SFLT_CMD_EMST_OFF];
	wire c_factory = wr_cmd & reg_wdata[`SFLT_CMD_FACTORY];
	wire c_loc_rst = wr_cmd & reg_wdata[`SFLT_CMD_LOC_RESET];
	wire protect_vf = cfg[`SFLT_CFG_PVF];
	wire manual = cfg[`SFLT_CFG_MAN];
	wire [7:0] brake_dly = cfg[`SFLT_CFG_BDLY_LSB+:8];

	// Trip reset sources
	wire both_rise = do_cw & do_ccw & ~cw_q & ~ccw_q;
	wire sup_reset = sup_rise & ~protect_vf;
	wire tr = both_rise | sup_reset | in_reset | c_loc_rst | key_rise | disc_rise;
	wire next_pi_err = do_cw & do_ccw & ~both_rise;

	// Factory restore request
	wire elems_off = ~motor_cw & ~motor_ccw;
	wire fs_cmd_ok = c_factory & manual & elems_off;
	wire fs_do = fs_cmd_ok | fs_knob;
	wire tr_any = tr | fs_do;
	wire [7:0] next_flt = fault_cause | (flt & ~{8{tr_any}});

	// Emergency start
	wire emi_rise = in_emst & ~emi_q;
	wire emi_fall = ~in_emst & emi_q;
	wire dev_err = st_err | elem_defective;
	wire blocked = off_cmd | dev_err | elem_overload | ~sup_sw | ~sup_el
		| blocking_trip | pi_err;
	wire group_fault = (|flt) | st_err | ttrip | elem_defective;
	wire allow = ~group_fault | (emst & ~blocked);
	wire swap = emst & limit_trip & group_fault;
	wire run_ok = allow & ~off_cmd & ~pi_err & ~ttrip & ~st_err;
	wire next_cw = run_ok & (swap ? do_ccw : do_cw) & ~(do_cw & do_ccw);
	wire next_ccw = run_ok & (swap ? do_cw : do_ccw) & ~(do_cw & do_ccw);
	wire brake_req = allow & brake_cmd & ~off_cmd & ~st_err;

	// Self-test step selection on release
	wire test_fall = test_q & ~test_cmd;
	wire t_short = tdur < 8'(`SFLT_T(`SFLT_HW_MIN_S));
	wire t_long = tdur > 8'(`SFLT_T(`SFLT_HW_MAX_S));
	wire ttrip_set = (tst == TST_IDLE) & test_fall & t_long & manual;

	// Logbook sources
	wire [7:0] ev_vec = {emst, warn};
	wire [1:0] dv_vec = {elem_defective, monitor_fail};
	always_comb begin
		newv[0] = {8'h00, fault_cause & ~flt};
		newv[1] = {ev_q & ~ev_vec, ev_vec & ~ev_q};
		newv[2] = {14'h0000, dv_vec & ~dv_q};
		lclr = {1'b0, c_del_ev, c_del_trip};
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			pin_s1 <= 4'h0;
			pin_s2 <= 4'h0;
			pin_q <= 4'h0;
		end else if (ce) begin
			pin_s1 <= {disconnect_on, key_zero, electronics_supply, switched_supply};
			pin_s2 <= pin_s1;
			pin_q <= pin_s2;
		end
	end

	// Tenth-second base and operating time in seconds
	always_ff @(posedge mclk) begin
		if (rst) begin
			tcnt <= 24'h00_0000;
			tick <= 1'b0;
			sub_s <= 4'h0;
			op_sec <= 32'h0000_0000;
		end else if (ce) begin
			tick <= (tcnt == 24'(TENTH_CYC - 1));
			tcnt <= (tcnt == 24'(TENTH_CYC - 1)) ? 24'h00_0000 : tcnt + 24'h00_0001;
			if (fs_do) begin
				sub_s <= 4'h0;
				op_sec <= 32'h0000_0000;
			end else if (tick) begin
				sub_s <= (sub_s == 4'(`SFLT_TENTHS_PER_S - 1)) ? 4'h0 : sub_s + 4'h1;
				if (sub_s == 4'(`SFLT_TENTHS_PER_S - 1)) begin
					op_sec <= op_sec + 32'h0000_0001;
				end
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			cfg <= `SFLT_CFG_RST;
			lsel <= 2'h0;
			lidx <= 5'h00;
		end else if (ce) begin
			if (wr_cfg) begin
				cfg <= reg_wdata[15:0];
			end
			if (wr_lsel) begin
				lsel <= (reg_wdata[1:0] == 2'h3) ? 2'h2 : reg_wdata[1:0];
				lidx <= reg_wdata[`SFLT_LOGSEL_IDX_LSB+:5];
			end
		end
	end

	// Fault and message state; every set wins over a clear in the same cycle
	always_ff @(posedge mclk) begin
		if (rst) begin
			cw_q <= 1'b0;
			ccw_q <= 1'b0;
			emi_q <= 1'b0;
			test_q <= 1'b0;
			ev_q <= 8'h00;
			dv_q <= 2'h0;
			flt <= 8'h00;
			emst <= 1'b0;
			st_err <= 1'b0;
			pi_err <= 1'b0;
			ttrip <= 1'b0;
			tr_done <= 1'b0;
			tr_fail <= 1'b0;
			fs_msg <= 1'b0;
		end else if (ce) begin
			cw_q <= do_cw;
			ccw_q <= do_ccw;
			emi_q <= in_emst;
			test_q <= test_cmd;
			ev_q <= ev_vec;
			dv_q <= dv_vec;
			flt <= next_flt;
			pi_err <= next_pi_err;
			if (c_emst_on | emi_rise) begin
				emst <= 1'b1;
			end else if (c_emst_off | emi_fall) begin
				emst <= 1'b0;
			end
			st_err <= st_err | monitor_fail;
			ttrip <= ttrip_set | (ttrip & ~tr_any);
			if (tr) begin
				tr_fail <= |(flt & fault_cause);
				tr_done <= ~|(flt & fault_cause);
			end
			fs_msg <= fs_do | (fs_msg & ~tr);
		end
	end

	// Logbooks: circular store per book
	for (genvar g = 0; g < `SFLT_LOG_COUNT; g++) begin : g_log
		wire [4:0] sel = sflt_low(pend[g]);
		wire [15:0] served = sel[4] ? (16'h0001 << sel[3:0]) : 16'h0000;
		wire [7:0] code = {sel[3], 4'h0, sel[2:0]};
		always_ff @(posedge mclk) begin
			if (rst) begin
				pend[g] <= 16'h0000;
				wp[g] <= 5'h00;
				lcnt[g] <= 5'h00;
			end else if (ce) begin
				pend[g] <= (pend[g] & ~(lclr[g] ? 16'h0000 : served)) | newv[g];
				if (lclr[g]) begin
					wp[g] <= 5'h00;
					lcnt[g] <= 5'h00;
				end else if (sel[4]) begin
					wp[g] <= (wp[g] == 5'(`SFLT_LOG_DEPTH - 1)) ? 5'h00 : wp[g] + 5'h01;
					if (lcnt[g] != 5'(`SFLT_LOG_DEPTH)) begin
						lcnt[g] <= lcnt[g] + 5'h01;
					end
				end
			end
		end
		always_ff @(posedge mclk) begin
			if (ce && sel[4] && !lclr[g]) begin
				log_mem[g][wp[g]] <= {code, op_sec};
			end
		end
	end

	// Index 0 is the newest entry
	wire [5:0] ra_t = {1'b0, wp[lsel]} + 6'(`SFLT_LOG_DEPTH - 1) - {1'b0, lidx};
	wire [4:0] ra = (ra_t >= 6'(`SFLT_LOG_DEPTH)) ? 5'(ra_t - 6'(`SFLT_LOG_DEPTH)) : ra_t[4:0];
	wire ent_ok = lidx < lcnt[lsel];
	wire [39:0] ent = ent_ok ? log_mem[lsel][ra] : 40'h00_0000_0000;
	wire [31:0] status = {8'h00, flt, 7'h00, ttrip, fs_msg, tr_fail, tr_done, pi_err,
		dev_err, st_err, emst, group_fault};

	always_comb begin
		next_rdata = 32'h0000_0000;
		if (!reg_rd) begin
			next_rdata = 32'h0000_0000;
		end else if (reg_addr == `SFLT_REG_CFG) begin
			next_rdata = {16'h0000, cfg};
		end else if (reg_addr == `SFLT_REG_STATUS) begin
			next_rdata = status;
		end else if (reg_addr == `SFLT_REG_LOGSEL) begin
			next_rdata = {19'h0_0000, lidx, 6'h00, lsel};
		end else if (reg_addr == `SFLT_REG_LOGCODE) begin
			next_rdata = {19'h0_0000, lcnt[lsel], ent[39:32]};
		end else if (reg_addr == `SFLT_REG_LOGSTAMP) begin
			next_rdata = ent[31:0];
		end else if (reg_addr == `SFLT_REG_HOURS) begin
			next_rdata = op_sec;
		end
	end

	// Self-test sequencer
	always_comb begin
		next_tst = tst;
		next_ttmr = tick ? ttmr + 8'h01 : ttmr;
		case (tst)
			TST_PON: begin
				if (tick) begin
					next_tst = TST_IDLE;
				end
			end
			TST_IDLE: begin
				next_ttmr = 8'h00;
				if (test_fall && t_short) begin
					next_tst = TST_LED;
				end else if (test_fall && !t_long) begin
					next_tst = TST_HW;
				end
			end
			TST_LED: begin
				if (ttmr >= 8'(`SFLT_T(`SFLT_LED_TEST_S))) begin
					next_tst = TST_IDLE;
				end
			end
			TST_HW: begin
				if (ttmr >= 8'(`SFLT_T(`SFLT_HW_RUN_S))) begin
					next_tst = TST_IDLE;
				end
			end
			default: begin
				next_tst = TST_IDLE;
			end
		endcase
	end

	// Knob sequence for factory restore
	always_comb begin
		next_fs = fs;
		next_ftmr = tick ? ftmr + 8'h01 : ftmr;
		fs_knob = 1'b0;
		case (fs)
			FS_IDLE: begin
				next_ftmr = 8'h00;
				if (disc_rise) begin
					next_fs = FS_SEQ;
				end
			end
			FS_SEQ: begin
				if (disc_fall) begin
					next_ftmr = 8'h00;
					fs_knob = (ftmr >= 8'(`SFLT_T(`SFLT_KNOB_MIN_S)));
					next_fs = fs_knob ? FS_SHOW : FS_IDLE;
				end else if (ftmr > 8'(`SFLT_T(`SFLT_KNOB_MAX_S))) begin
					next_fs = FS_IDLE;
				end
			end
			FS_SHOW: begin
				if (ftmr >= 8'(`SFLT_T(`SFLT_FS_SHOW_S))) begin
					next_fs = FS_IDLE;
				end
			end
			default: begin
				next_fs = FS_IDLE;
			end
		endcase
		if (fs_cmd_ok && fs != FS_SEQ) begin
			next_fs = FS_SHOW;
			next_ftmr = 8'h00;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			tst <= TST_PON;
			ttmr <= 8'h00;
			tdur <= 8'h00;
			fs <= FS_IDLE;
			ftmr <= 8'h00;
		end else if (ce) begin
			tst <= next_tst;
			ttmr <= next_ttmr;
			// Saturates so a very long press still reads as over the top limit
			tdur <= !test_cmd ? 8'h00 : (tick && tdur != 8'hff) ? tdur + 8'h01 : tdur;
			fs <= next_fs;
			ftmr <= next_ftmr;
		end
	end

	// LED blink bases: flicker toggles every tenth, flash every half second
	always_ff @(posedge mclk) begin
		if (rst) begin
			blc <= 3'h0;
			flash <= 1'b0;
			flick <= 1'b0;
		end else if (ce && tick) begin
			flick <= ~flick;
			blc <= (blc == 3'(`SFLT_FLASH_TENTHS - 1)) ? 3'h0 : blc + 3'h1;
			if (blc == 3'(`SFLT_FLASH_TENTHS - 1)) begin
				flash <= ~flash;
			end
		end
	end

	wire led_all = (tst == TST_LED);
	wire next_dev_led = (fs == FS_SEQ) ? flash :
		(fs == FS_SHOW) ? flick :
		st_err ? 1'b1 :
		led_all ? 1'b1 :
		(tst == TST_HW) ? (current_flow ? flash : flick) :
		elem_defective;
	wire fs_quiet = (fs != FS_IDLE);
	wire next_gf_led = ~fs_quiet & (led_all | group_fault);
	wire next_stat_led = ~fs_quiet & (led_all | ~group_fault);

	// Brake release delay counted in tenths
	always_ff @(posedge mclk) begin
		if (rst) begin
			bcnt <= 8'h00;
		end else if (ce) begin
			bcnt <= !brake_req ? 8'h00 : (tick && bcnt != 8'hff) ? bcnt + 8'h01 : bcnt;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			reg_rdata <= 32'h0000_0000;
			motor_cw <= 1'b0;
			motor_ccw <= 1'b0;
			brake_on <= 1'b0;
			motor_model_clear <= 1'b0;
			device_led_red <= 1'b0;
			group_fault_led <= 1'b0;
			status_led <= 1'b0;
		end else if (ce) begin
			reg_rdata <= next_rdata;
			motor_cw <= next_cw;
			motor_ccw <= next_ccw;
			brake_on <= brake_req & (bcnt >= brake_dly);
			motor_model_clear <= fs_do;
			device_led_red <= next_dev_led;
			group_fault_led <= next_gf_led;
			status_led <= next_stat_led;
		end
	end
endmodule : sflt_core

// File: verilog/sflt_defs.svh
// Constants of the starter fault log and test block
`ifndef SFLT_DEFS_SVH
`define SFLT_DEFS_SVH
`define SFLT_LOG_DEPTH 21
`define SFLT_LOG_COUNT 3
`define SFLT_CLK_MHZ 125
`define SFLT_TENTH_MS 100
`define SFLT_TENTH_CYC (`SFLT_TENTH_MS * 1000 * `SFLT_CLK_MHZ)
`define SFLT_TENTHS_PER_S 10
`define SFLT_T(s) ((s) * `SFLT_TENTHS_PER_S)
`define SFLT_LED_TEST_S 2
`define SFLT_HW_MIN_S 2
`define SFLT_HW_MAX_S 5
`define SFLT_HW_RUN_S 2
`define SFLT_KNOB_MIN_S 2
`define SFLT_KNOB_MAX_S 4
`define SFLT_FS_SHOW_S 5
`define SFLT_FLASH_TENTHS 5
`define SFLT_REG_CMD 8'h00
`define SFLT_REG_CFG 8'h04
`define SFLT_REG_STATUS 8'h08
`define SFLT_REG_LOGSEL 8'h0c
`define SFLT_REG_LOGCODE 8'h10
`define SFLT_REG_LOGSTAMP 8'h14
`define SFLT_REG_HOURS 8'h18
`define SFLT_CMD_DEL_TRIP 0
`define SFLT_CMD_DEL_EV 1
`define SFLT_CMD_EMST_ON 2
`define SFLT_CMD_EMST_OFF 3
`define SFLT_CMD_FACTORY 4
`define SFLT_CMD_LOC_RESET 5
`define SFLT_CFG_PVF 0
`define SFLT_CFG_MAN 1
`define SFLT_CFG_BDLY_LSB 8
`define SFLT_CFG_RST 16'h0000
`define SFLT_LOGSEL_IDX_LSB 8
`define SFLT_ST_GF 0
`define SFLT_ST_EMST 1
`define SFLT_ST_STERR 2
`define SFLT_ST_DEVERR 3
`define SFLT_ST_PIERR 4
`define SFLT_ST_TR_DONE 5
`define SFLT_ST_TR_FAIL 6
`define SFLT_ST_FS_DONE 7
`define SFLT_ST_TTRIP 8
`define SFLT_ST_FLT_LSB 16
`endif

// File: verilog/sflt_pkg.sv
// Types of the starter fault log and test block
package sflt_pkg;
	typedef enum logic [3:0] {
		TST_PON = 4'b0001,
		TST_IDLE = 4'b0010,
		TST_LED = 4'b0100,
		TST_HW = 4'b1000
	} sflt_tst_t;
	typedef enum logic [2:0] {
		FS_IDLE = 3'b001,
		FS_SEQ = 3'b010,
		FS_SHOW = 3'b100
	} sflt_fs_t;
	typedef logic [39:0] sflt_entry_t;
endpackage : sflt_pkg
